// [logic/dtm_consts.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef DTM_CONSTS_SVH
`define DTM_CONSTS_SVH
// Byte offsets on the register bus
`define DTM_RUN_OVF 8'h00
`define DTM_OUT_DIV 8'h04
`define DTM_MODE_SEL 8'h08
`define DTM_TL0 8'h0c
`define DTM_TH0 8'h10
`define DTM_TL1 8'h14
`define DTM_TH1 8'h18
`define DTM_RLD_CTRL 8'h1c
`define DTM_RLD_LO 8'h20
`define DTM_RLD_HI 8'h24
`define DTM_IRQ_EN2 8'h28
// Field positions
`define DTM_TF1_BIT 7
`define DTM_TR1_BIT 6
`define DTM_TF0_BIT 5
`define DTM_TR0_BIT 4
`define DTM_OUT1_BIT 5
`define DTM_X121_BIT 4
`define DTM_OUT0_BIT 1
`define DTM_X120_BIT 0
`define DTM_R_TF_BIT 7
`define DTM_R_PD_BIT 6
`define DTM_R_TR_BIT 2
`define DTM_ET3_BIT 1
// Reset values and counts
`define DTM_RST_BYTE 8'h00
`define DTM_SYS_MHZ 20
`define DTM_DIV12 12
`define DTM_DIV12_LAST 4'(`DTM_DIV12 - 1)
`define DTM_ONES16 16'hffff
`define DTM_ONES8 8'hff
`define DTM_CLK_EXT 2'b01
`endif

// [logic/dtm_pkg.sv]
// Types shared by the timer block
package dtm_pkg;
  // Mode field codes of the general timers
  typedef enum logic [1:0] {
    DTM_M_RLD16 = 2'b00,
    DTM_M_CNT16 = 2'b01,
    DTM_M_RLD8 = 2'b10,
    DTM_M_SPLIT = 2'b11
  } dtm_mode_t;

  // Complete state of the timer block
  typedef struct packed {
    logic [3:0] div12;
    logic [2:0] prev_pin;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] rld;
    logic [1:0][7:0] hbuf;
    logic [1:0] tf;
    logic [1:0] tr;
    logic [1:0] out_en;
    logic [1:0] x12;
    logic [1:0] tout;
    logic [7:0] timer_mode_select;
    logic [15:0] t3cnt;
    logic [15:0] t3rld;
    logic tf3;
    logic t3pd_en;
    logic tr3;
    logic [1:0] t3ps;
    logic [1:0] t3clks;
    logic [7:0] t3psc;
    logic et3;
    logic [31:0] rdata;
  } dtm_state_t;
endpackage

// [logic/dtm_timer.sv]
// Dual general timer plus 16-bit reload timer with APB registers
//
// The APB register port and the register offsets were decided locally.
`include "dtm_consts.svh"

module dtm_timer (
  input wire logic clock, // System clock, 20 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high writes
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [1:0] external_gate_pin, // Gate levels per timer
  input wire logic [1:0] count_pin, // External count pins
  input wire logic reload_clk_pin, // Reload timer pin clock
  input wire logic power_down, // Chip is in power-down
  input wire logic [1:0] irq_ack, // Interrupt taken, per timer
  output logic [1:0] timer_irq, // Overflow requests, timers 0/1
  output logic reload_irq, // Reload timer request
  output logic [1:0] toggle_pin // Overflow toggle outputs
);
  import dtm_pkg::*;

  dtm_state_t s;
  dtm_state_t n;
  logic tick12;
  logic [2:0] fall;
  logic [1:0] en;
  logic [1:0] tick;
  logic [1:0] it_tick;
  logic [1:0] ovf;
  logic [1:0] setf;
  logic t3_src;
  logic t3_step;
  logic [7:0] psc_mask;
  logic wr;
  logic rd_setup;
  logic mapped;
  dtm_mode_t m0;
  dtm_mode_t m1;

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake: zero wait states, read data latched in setup
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign pready = psel & penable;
  assign prdata = s.rdata;
  assign m0 = dtm_mode_t'(s.timer_mode_select[1:0]);
  assign m1 = dtm_mode_t'(s.timer_mode_select[5:4]);

  // Decode of the mapped offsets
  always_comb begin
    unique case (paddr)
      `DTM_RUN_OVF, `DTM_OUT_DIV, `DTM_MODE_SEL, `DTM_TL0, `DTM_TH0,
      `DTM_TL1, `DTM_TH1, `DTM_RLD_CTRL, `DTM_RLD_LO, `DTM_RLD_HI,
      `DTM_IRQ_EN2: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~mapped;

  // Request outputs straight from flags; the reload request is masked by et3
  assign timer_irq = s.tf;
  assign reload_irq = s.tf3 & s.et3;
  assign toggle_pin = s.tout;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic of the whole block
  always_comb begin
    n = s;
    // Shared divide-by-twelve strobe
    tick12 = (s.div12 == `DTM_DIV12_LAST);
    n.div12 = tick12 ? 4'h0 : s.div12 + 4'h1;
    // Pins are synchronous; one stage is enough for edges
    n.prev_pin = {reload_clk_pin, count_pin};
    fall = s.prev_pin & ~{reload_clk_pin, count_pin};
    ovf = 2'b00;
    setf = 2'b00;

    // Per-timer enables and count strobes
    for (int i = 0; i < 2; i++) begin
      it_tick[i] = s.x12[i] | tick12;
      tick[i] = s.timer_mode_select[4*i+2] ? fall[i] : it_tick[i];
      en[i] = s.tr[i] & (~s.timer_mode_select[4*i+3] | external_gate_pin[i]);
    end
    // Timer one runs by mode alone while timer zero is split
    if (m0 == DTM_M_SPLIT) begin
      en[1] = (m1 != DTM_M_SPLIT);
      tick[1] = it_tick[1];
    end
    if (m1 == DTM_M_SPLIT) begin
      en[1] = 1'b0;
    end

    // Counting for both general timers
    for (int i = 0; i < 2; i++) begin
      if (en[i] && tick[i]) begin
        unique case (s.timer_mode_select[4*i +: 2])
          DTM_M_RLD16: begin
            ovf[i] = (s.cnt[i] == `DTM_ONES16);
            n.cnt[i] = ovf[i] ? s.rld[i] : s.cnt[i] + 16'h0001;
          end
          DTM_M_CNT16: begin
            ovf[i] = (s.cnt[i] == `DTM_ONES16);
            n.cnt[i] = s.cnt[i] + 16'h0001;
          end
          default: begin
            // Eight-bit low byte; reload from high byte in mode 2
            ovf[i] = (s.cnt[i][7:0] == `DTM_ONES8);
            if (!ovf[i]) begin
              n.cnt[i][7:0] = s.cnt[i][7:0] + 8'h01;
            end else if (s.timer_mode_select[4*i +: 2] == DTM_M_RLD8) begin
              n.cnt[i][7:0] = s.cnt[i][15:8];
            end else begin
              n.cnt[i][7:0] = 8'h00;
            end
          end
        endcase
      end
    end
    setf[0] = ovf[0];
    setf[1] = ovf[1] & (m0 != DTM_M_SPLIT);
    // Split high byte: internal clock, timer one's run and flag
    if (m0 == DTM_M_SPLIT && s.tr[1] && it_tick[0]) begin
      n.cnt[0][15:8] = s.cnt[0][15:8] + 8'h01;
      setf[1] = (s.cnt[0][15:8] == `DTM_ONES8);
    end
    // Toggle pins follow each timer's own overflow
    for (int i = 0; i < 2; i++) begin
      if (ovf[i] && s.out_en[i]) begin
        n.tout[i] = ~s.tout[i];
      end
    end

    // Reload timer prescaler and counter
    t3_src = (s.t3clks == `DTM_CLK_EXT) ? fall[2] : ~power_down;
    unique case (s.t3ps)
      2'b00: psc_mask = 8'h00;
      2'b01: psc_mask = 8'h07;
      2'b10: psc_mask = 8'h3f;
      default: psc_mask = 8'hff;
    endcase
    t3_step = 1'b0;
    if (s.tr3 && t3_src) begin
      t3_step = ((s.t3psc | ~psc_mask) == `DTM_ONES8);
      n.t3psc = t3_step ? 8'h00 : s.t3psc + 8'h01;
    end
    if (t3_step) begin
      if (s.t3cnt == `DTM_ONES16) begin
        n.t3cnt = s.t3rld;
        n.tf3 = 1'b1;
      end else begin
        n.t3cnt = s.t3cnt + 16'h0001;
      end
    end

    // Flags: ack clears, then software, then hardware set wins
    for (int i = 0; i < 2; i++) begin
      if (irq_ack[i]) begin
        n.tf[i] = 1'b0;
      end
    end
    if (wr && paddr == `DTM_RUN_OVF) begin
      n.tf = {pwdata[`DTM_TF1_BIT], pwdata[`DTM_TF0_BIT]};
      n.tr = {pwdata[`DTM_TR1_BIT], pwdata[`DTM_TR0_BIT]};
    end
    n.tf = n.tf | setf;

    // Remaining register writes
    if (wr) begin
      unique case (paddr)
        `DTM_OUT_DIV: begin
          n.out_en = {pwdata[`DTM_OUT1_BIT], pwdata[`DTM_OUT0_BIT]};
          n.x12 = {pwdata[`DTM_X121_BIT], pwdata[`DTM_X120_BIT]};
        end
        `DTM_MODE_SEL: n.timer_mode_select = pwdata[7:0];
        `DTM_RLD_CTRL: begin
          if (!pwdata[`DTM_R_TF_BIT]) begin
            n.tf3 = t3_step & (s.t3cnt == `DTM_ONES16);
          end
          n.t3pd_en = pwdata[`DTM_R_PD_BIT];
          n.t3ps = pwdata[5:4];
          n.tr3 = pwdata[`DTM_R_TR_BIT];
          n.t3clks = pwdata[1:0];
        end
        `DTM_RLD_LO: begin
          n.t3rld[7:0] = pwdata[7:0];
          if (!s.tr3) begin
            n.t3cnt[7:0] = pwdata[7:0];
          end
        end
        `DTM_RLD_HI: begin
          n.t3rld[15:8] = pwdata[7:0];
          if (!s.tr3) begin
            n.t3cnt[15:8] = pwdata[7:0];
          end
        end
        `DTM_IRQ_EN2: n.et3 = pwdata[`DTM_ET3_BIT];
        default: ;
      endcase
    end

    // Count byte writes; mode 0 buffers the high byte
    for (int i = 0; i < 2; i++) begin
      if (wr && paddr == (i == 0 ? `DTM_TH0 : `DTM_TH1)) begin
        if (s.timer_mode_select[4*i +: 2] == DTM_M_RLD16) begin
          n.hbuf[i] = pwdata[7:0];
        end else begin
          n.cnt[i][15:8] = pwdata[7:0];
        end
      end
      if (wr && paddr == (i == 0 ? `DTM_TL0 : `DTM_TL1)) begin
        if (s.timer_mode_select[4*i +: 2] == DTM_M_RLD16) begin
          n.rld[i] = {s.hbuf[i], pwdata[7:0]};
          if (!s.tr[i]) begin
            n.cnt[i] = {s.hbuf[i], pwdata[7:0]};
          end
        end else begin
          n.cnt[i][7:0] = pwdata[7:0];
        end
      end
    end

    // Read data captured in the setup cycle
    if (rd_setup) begin
      n.rdata = 32'h0000_0000;
      unique case (paddr)
        `DTM_RUN_OVF:
          n.rdata[7:4] = {s.tf[1], s.tr[1], s.tf[0], s.tr[0]};
        `DTM_OUT_DIV:
          n.rdata[7:0] = {2'b00, s.out_en[1], s.x12[1],
                          2'b00, s.out_en[0], s.x12[0]};
        `DTM_MODE_SEL: n.rdata[7:0] = s.timer_mode_select;
        `DTM_TL0: n.rdata[7:0] = s.cnt[0][7:0];
        `DTM_TH0: n.rdata[7:0] = s.cnt[0][15:8];
        `DTM_TL1: n.rdata[7:0] = s.cnt[1][7:0];
        `DTM_TH1: n.rdata[7:0] = s.cnt[1][15:8];
        `DTM_RLD_CTRL:
          n.rdata[7:0] = {s.tf3, s.t3pd_en, s.t3ps, 1'b0, s.tr3,
                          s.t3clks};
        `DTM_RLD_LO: n.rdata[7:0] = s.t3cnt[7:0];
        `DTM_RLD_HI: n.rdata[7:0] = s.t3cnt[15:8];
        `DTM_IRQ_EN2: n.rdata[`DTM_ET3_BIT] = s.et3;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; everything resets to zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the block's own behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_flag_on_ovf: assert property (
    ovf[0] |=> s.tf[0])
    else $error("timer zero overflow did not set its flag");

  a_run_stop_hold: assert property (
    !s.tr[0] && m0 == DTM_M_CNT16 && !wr |=> $stable(s.cnt[0]))
    else $error("stopped timer zero changed its count");

  a_reserved_zero: assert property (
    pready && !pwrite && paddr == `DTM_OUT_DIV
      |-> prdata[7:6] == 2'b00 && prdata[3:2] == 2'b00)
    else $error("reserved divide bits read nonzero");

  a_toggle_pin: assert property (
    ovf[1] && s.out_en[1] |=> toggle_pin[1] != $past(toggle_pin[1]))
    else $error("enabled output did not toggle on overflow");

  a_div12_gap: assert property (
    tick12 |=> !tick12 [*8])
    else $error("divide by twelve strobe came too early");

  a_gate_block: assert property (
    s.timer_mode_select[3] && !external_gate_pin[0] && m0 == DTM_M_CNT16 && !wr
      |=> $stable(s.cnt[0]))
    else $error("gated timer counted with pin low");

  a_ext_fall: assert property (
    s.timer_mode_select[2] && en[0] && fall[0] && m0 == DTM_M_CNT16 && !wr
      |=> s.cnt[0] == $past(s.cnt[0]) + 16'h0001)
    else $error("external falling edge not counted");

  a_split_stop: assert property (
    m1 == DTM_M_SPLIT && !wr |=> $stable(s.cnt[1]))
    else $error("timer one counted in split code");

  a_buf_high: assert property (
    wr && paddr == `DTM_TH0 && m0 == DTM_M_RLD16
      |=> $stable(s.rld[0]) && s.hbuf[0] == $past(pwdata[7:0]))
    else $error("mode 0 high byte write not buffered");

  a_t3_reload: assert property (
    t3_step && s.t3cnt == `DTM_ONES16 && !wr
      |=> s.t3cnt == $past(s.t3rld) && s.tf3)
    else $error("reload timer missed reload or flag");

  a_t3_run_wr: assert property (
    s.tr3 && !t3_step && wr && paddr == `DTM_RLD_LO
      |=> $stable(s.t3cnt) && s.t3rld[7:0] == $past(pwdata[7:0]))
    else $error("running reload timer counter disturbed by write");

  a_t3_pd: assert property (
    power_down && s.t3clks != `DTM_CLK_EXT && !wr |=> $stable(s.t3cnt))
    else $error("reload timer ran in power-down on system clock");

  a_t3_irq_en: assert property (
    !s.et3 |-> !reload_irq)
    else $error("reload interrupt raised while disabled");

  // Timer zero is the one the bench overflows with its output enabled
  a_toggle_zero: assert property (
    ovf[0] && s.out_en[0] |=> toggle_pin[0] != $past(toggle_pin[0]))
    else $error("timer zero output did not toggle on overflow");

  // A disabled output must hold its level through any overflow
  a_toggle_off: assert property (
    !s.out_en[0] |=> toggle_pin[0] == $past(toggle_pin[0]))
    else $error("disabled output pin changed level");

  // Interrupt taken clears the flag unless a new overflow wins
  a_ack_clear: assert property (
    irq_ack[0] && !setf[0] && !wr |=> !s.tf[0])
    else $error("taken interrupt left the flag set");

  // Eight-bit reload mode refills the low byte from the high byte
  a_m2_reload: assert property (
    en[0] && tick[0] && m0 == DTM_M_RLD8 && !wr
      && s.cnt[0][7:0] == `DTM_ONES8
      |=> s.cnt[0][7:0] == $past(s.cnt[0][15:8]))
    else $error("eight-bit mode missed its reload");

  // Split high byte overflow raises timer one's flag
  a_split_flag: assert property (
    m0 == DTM_M_SPLIT && s.tr[1] && it_tick[0]
      && s.cnt[0][15:8] == `DTM_ONES8 |=> s.tf[1])
    else $error("split high byte overflow did not set flag");

  // Stopped reload timer takes a data write into counter and reload
  a_t3_stop_wr: assert property (
    !s.tr3 && wr && paddr == `DTM_RLD_HI
      |=> s.t3cnt[15:8] == $past(pwdata[7:0])
        && s.t3rld[15:8] == $past(pwdata[7:0]))
    else $error("stopped reload timer write missed the counter");
endmodule

// [dv/tb_dtm_timer.sv]
// Self-checking bench for the dual timer and reload timer block
`include "dtm_consts.svh"
module tb_dtm_timer;
  timeunit 1ns;
  timeprecision 1ns;
  import dtm_pkg::*;
  logic clock, nrst, psel, penable, pwrite, pslverr, pready, se;
  logic [7:0] paddr, d, hb;
  logic [31:0] pwdata, prdata, seed;
  logic [1:0] external_gate_pin, count_pin, irq_ack, timer_irq, toggle_pin;
  logic reload_clk_pin, power_down, reload_irq;
  logic [2:0] irqs;
  int err_count, n_compared, n;
  assign irqs = {reload_irq, timer_irq};

  dtm_timer dut (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .external_gate_pin(external_gate_pin), .count_pin(count_pin),
    .reload_clk_pin(reload_clk_pin), .power_down(power_down),
    .irq_ack(irq_ack), .timer_irq(timer_irq), .reload_irq(reload_irq),
    .toggle_pin(toggle_pin)
  );

  ////////////////////////////////////////////////////////////////////////
  // 50 ns system clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  // Expectation helpers; the lfsr feeds the random cases
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic inr(input logic [15:0] v, input int lo, hi);
    return v >= lo && v <= hi;
  endfunction
  function automatic int exp_ps(input int p);
    return 512 / (p == 0 ? 1 : p == 1 ? 8 : p == 2 ? 64 : 256);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus and pin tasks
  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    d = prdata[7:0];
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, v);
    xfer(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 8'h00);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, e, input string nm);
    rd(a);
    chk(nm, e, d);
  endtask
  // High byte first, then low byte, as software must
  task automatic ld(input logic [7:0] ha, h, l);
    wr(ha, h);
    wr(ha - 8'h04, l);
  endtask
  // Falling edges on a count pin; index 2 is the reload pin clock
  task automatic pls(input int k, c);
    repeat (c) begin
      @(posedge clock);
      if (k == 2) reload_clk_pin <= 1'b1;
      else count_pin[k] <= 1'b1;
      cyc(2);
      if (k == 2) reload_clk_pin <= 1'b0;
      else count_pin[k] <= 1'b0;
      cyc(2);
    end
  endtask
  // Bounded wait; outputs looked at after the edge has settled
  task automatic wirq(input int k);
    n = 0;
    while (irqs[k] !== 1'b1 && n < 400) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("irq", 1'b1, irqs[k]);
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the few thousand cycles the tests need
  initial begin
    cyc(20000);
    err_count++;
    $display("[ERR] watchdog expected end seen hang");
    finish_test;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {external_gate_pin, count_pin, irq_ack} = '0;
    {reload_clk_pin, power_down} = '0;
    err_count = 0;
    n_compared = 0;
    seed = 32'h8788;
    cyc(8);
    nrst <= 1'b1;
    for (int a = 0; a <= 8'h28; a += 4) rchk(8'(a), 8'h00, "reset");
    rd(8'h2c);
    chk("pslverr", 1'b1, se);
    wr(`DTM_OUT_DIV, 8'hff);
    rchk(`DTM_OUT_DIV, 8'h33, "outdiv");
    done("registers");
    // 16-bit overflow, toggle output, interrupt taken
    wr(`DTM_MODE_SEL, 8'h11);
    ld(`DTM_TH0, 8'hff, 8'hfe);
    chk("toggle", 1'b0, toggle_pin[0]);
    wr(`DTM_RUN_OVF, 8'h10);
    wirq(0);
    cyc(2);
    #1;
    chk("toggle", 1'b1, toggle_pin[0]);
    cyc(1);
    irq_ack <= 2'b01;
    cyc(1);
    irq_ack <= 2'b00;
    cyc(2);
    #1;
    chk("ack", 1'b0, timer_irq[0]);
    done("overflow");
    // Divide by twelve, then a stopped count holds
    wr(`DTM_OUT_DIV, 8'h22);
    ld(`DTM_TH0, 8'h00, 8'h00);
    wr(`DTM_RUN_OVF, 8'h10);
    cyc(240);
    wr(`DTM_RUN_OVF, 8'h00);
    rd(`DTM_TL0);
    chk("div12", 1'b1, inr(d, 243 / `DTM_DIV12, 243 / `DTM_DIV12 + 1));
    hb = d;
    cyc(20);
    rchk(`DTM_TL0, hb, "stopped");
    // Gate pin low blocks counting, high lets it run
    wr(`DTM_OUT_DIV, 8'h33);
    wr(`DTM_MODE_SEL, 8'h19);
    ld(`DTM_TH0, 8'h00, 8'h00);
    wr(`DTM_RUN_OVF, 8'h10);
    cyc(40);
    wr(`DTM_RUN_OVF, 8'h00);
    rchk(`DTM_TL0, 8'h00, "gate low");
    external_gate_pin <= 2'b01;
    wr(`DTM_RUN_OVF, 8'h10);
    cyc(40);
    wr(`DTM_RUN_OVF, 8'h00);
    rd(`DTM_TL0);
    chk("gate high", 1'b1, inr(d, 41, 45));
    done("clocking");
    // Random number of falling edges on the count pin
    seed = lfsr(seed);
    wr(`DTM_MODE_SEL, 8'h15);
    ld(`DTM_TH0, 8'h00, 8'h00);
    wr(`DTM_RUN_OVF, 8'h10);
    pls(0, seed[3:0] + 1);
    cyc(3);
    wr(`DTM_RUN_OVF, 8'h00);
    rchk(`DTM_TL0, 8'(seed[3:0] + 1), "ext count");
    done("counter");
    // Buffered high byte in 16-bit reload mode
    wr(`DTM_MODE_SEL, 8'h10);
    ld(`DTM_TH0, 8'h12, 8'h34);
    rchk(`DTM_TL0, 8'h34, "m0 low");
    wr(`DTM_TH0, 8'hff);
    rchk(`DTM_TH0, 8'h12, "m0 buf");
    wr(`DTM_TL0, 8'hf0);
    rchk(`DTM_TH0, 8'hff, "m0 pair");
    wr(`DTM_RUN_OVF, 8'h10);
    wirq(0);
    rchk(`DTM_TH0, 8'hff, "m0 reload");
    wr(`DTM_RUN_OVF, 8'h00);
    #1;
    chk("sw clear", 1'b0, timer_irq[0]);
    // 8-bit reload mode
    wr(`DTM_MODE_SEL, 8'h12);
    ld(`DTM_TH0, 8'hf0, 8'hfc);
    wr(`DTM_RUN_OVF, 8'h10);
    wirq(0);
    rd(`DTM_TL0);
    chk("m2 reload", 1'b1, inr(d, 8'hf0, 8'hf8));
    rchk(`DTM_TH0, 8'hf0, "m2 keep");
    wr(`DTM_RUN_OVF, 8'h00);
    // Split mode: upper byte borrows timer one run bit and flag
    seed = lfsr(seed);
    wr(`DTM_MODE_SEL, 8'h33);
    ld(`DTM_TH1, 8'h00, seed[7:0]);
    ld(`DTM_TH0, 8'hfe, 8'h00);
    wr(`DTM_RUN_OVF, 8'h40);
    wirq(1);
    rchk(`DTM_TL0, 8'h00, "split low");
    rchk(`DTM_TL1, seed[7:0], "t1 stop");
    wr(`DTM_RUN_OVF, 8'h00);
    done("modes");
    // Reload timer: stopped loads counter, running loads reload only
    wr(`DTM_IRQ_EN2, 8'h02);
    ld(`DTM_RLD_HI, 8'hff, 8'h00);
    rchk(`DTM_RLD_HI, 8'hff, "t3 hi");
    rchk(`DTM_RLD_LO, 8'h00, "t3 lo");
    wr(`DTM_RLD_CTRL, 8'h04);
    ld(`DTM_RLD_HI, 8'hff, 8'hf0);
    rd(`DTM_RLD_LO);
    chk("t3 run", 1'b1, inr(d, 8'h00, 8'h40));
    wirq(2);
    rd(`DTM_RLD_LO);
    chk("t3 rld", 1'b1, inr(d, 8'hf0, 8'hfc));
    wr(`DTM_IRQ_EN2, 8'h00);
    #1;
    chk("t3 masked", 1'b0, reload_irq);
    rd(`DTM_RLD_CTRL);
    chk("t3 flag", 1'b1, d[`DTM_R_TF_BIT]);
    wr(`DTM_RLD_CTRL, 8'h00);
    // Every prescale code over 512 cycles
    for (int p = 0; p < 4; p++) begin
      ld(`DTM_RLD_HI, 8'h00, 8'h00);
      wr(`DTM_RLD_CTRL, 8'(p << 4) | 8'h04);
      cyc(509);
      wr(`DTM_RLD_CTRL, 8'h00);
      rd(`DTM_RLD_HI);
      hb = d;
      rd(`DTM_RLD_LO);
      chk("prescale", 1'b1, inr({hb, d}, exp_ps(p) - 1, exp_ps(p) + 1));
    end
    // Power-down: system clock source idle, pin clock counts
    power_down <= 1'b1;
    seed = lfsr(seed);
    ld(`DTM_RLD_HI, 8'h00, 8'h00);
    wr(`DTM_RLD_CTRL, 8'h04);
    cyc(50);
    rchk(`DTM_RLD_LO, 8'h00, "pd sys");
    wr(`DTM_RLD_CTRL, 8'h05);
    pls(2, seed[3:0] + 1);
    cyc(3);
    wr(`DTM_RLD_CTRL, 8'h01);
    rchk(`DTM_RLD_LO, 8'(seed[3:0] + 1), "pd pin");
    power_down <= 1'b0;
    done("reload timer");
    finish_test;
  end
endmodule
